// ===== lpt_pkg.sv
// package: constants and types for the low-power state and thermal throttle block
// assumes: one 125 MHz clock; all pins already synchronous to it
`default_nettype none
package lpt_pkg;
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_HALTED = 5'h02,
    ST_GRANT  = 5'h04,
    ST_SNOOP  = 5'h08,
    ST_SLEEP  = 5'h10
  } lpt_state_e;

  // grant acknowledge sequencing
  typedef enum logic [2:0] {
    AK_IDLE = 3'h1,
    AK_WAIT = 3'h2,
    AK_CNT  = 3'h4
  } lpt_ack_e;

  typedef struct packed {
    logic       autoEn;
    logic       demandEn;
    logic [2:0] demandDuty;
  } lpt_thermctl_s;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned GRANT_DELAY   = 20;
  localparam int unsigned MAX_PERIOD_US = 3000;
  localparam int unsigned MAX_PERIOD_CY = MAX_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MOD_STEP_CY   = 8192;
  localparam int unsigned HYST_CY       = 65536;
  localparam logic [2:0]  AUTO_DUTY     = 3'h3;

  // wishbone map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PEND   = 4'h8;
  localparam int unsigned CTRL_DEMAND_BIT = 4;
  localparam int unsigned CTRL_DUTY_LSB   = 1;
  localparam int unsigned CTRL_AUTO_BIT   = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
endpackage
`default_nettype wire

// ===== lpt_event_latch.sv
// one latched wake event: set wins over clear
// assumes: synchronous inputs, clock shared with the top
`default_nettype none
module lpt_event_latch
  import lpt_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // event
  input  wire logic setEv,
  input  wire logic clrEv,
  output logic      pendReg
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pendReg <= 1'b0;
    end else if (setEv) begin
      pendReg <= 1'b1;
    end else if (clrEv) begin
      pendReg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== lpt_duty_mod.sv
// clock gate modulator: 8 slots per period, duty in eighths on
// assumes: step length keeps whole period below the longest allowed on or off time
`default_nettype none
module lpt_duty_mod
  import lpt_pkg::*;
#(
  parameter int unsigned STEP_CY = MOD_STEP_CY
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       run,
  input  wire logic [2:0] duty,
  output logic            gateOn
);
  logic [$clog2(STEP_CY)-1:0] divReg;
  logic [2:0]                 slotReg;

  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      divReg  <= '0;
      slotReg <= 3'h0;
    end else if (divReg == ($clog2(STEP_CY))'(STEP_CY - 1)) begin
      divReg  <= '0;
      slotReg <= slotReg + 3'h1;
    end else begin
      divReg <= divReg + 1'b1;
    end
  end

  // on for duty+1 slots of eight: 12.5% .. 100%
  assign gateOn = !run || (slotReg <= duty);
endmodule
`default_nettype wire

// ===== lpt_power_ctrl.sv
// low-power state machine and thermal throttle with wishbone control registers
// assumes: pins synchronous to clk; chipset keeps its sideband rules
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`default_nettype none
module lpt_power_ctrl
  import lpt_pkg::*;
#(
  parameter int unsigned HYST = HYST_CY,
  parameter int unsigned STEP = MOD_STEP_CY
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // sideband pins, active low except local_interrupt_lines, which are active high
  input  wire logic        stop_clock_request_n,
  input  wire logic        sleep_request_n,
  input  wire logic        bus_init_n,
  input  wire logic        soft_init_n,
  input  wire logic        proc_reset_n,
  input  wire logic [1:0]  local_interrupt_lines,
  // core and bus events
  input  wire logic        haltExec,
  input  wire logic        busIntr,
  input  wire logic        snoopSeen,
  input  wire logic        snoopDone,
  input  wire logic        ackResponse,
  input  wire logic        busInitDone,
  // thermal trip inputs
  input  wire logic        tempHigh,
  input  wire logic        tempCatastrophic,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // outputs
  output logic      [4:0]  lpState,
  output logic             grantAckCycle,
  output logic             coreClkEn,
  output logic             coreInit,
  output logic      [3:0]  wakeService,
  output logic             overtemp_active_n,
  output logic             thermal_shutdown_n
);
  lpt_state_e    stateReg;
  lpt_state_e    stateNext;
  lpt_state_e    stateNew;
  logic          grantFromHaltReg;
  logic          wbWr;
  lpt_state_e    snoopRetReg;
  lpt_ack_e      ackReg;
  logic [4:0]    ackCntReg;
  logic          grantReadyReg;
  lpt_thermctl_s ctlReg;
  logic [31:0]   hystReg;
  logic          throttleReg;
  logic          shutdownReg;
  logic          ackReg_o;
  logic [3:0]    pend;
  logic [3:0]    evIn;
  logic          gateOn;
  logic          stpc;
  logic          slp;
  logic          wake;
  logic          wbHit;

  assign stpc  = !stop_clock_request_n;
  assign slp   = !sleep_request_n;
  assign evIn  = {!soft_init_n, !bus_init_n, local_interrupt_lines};
  assign wake  = !bus_init_n || !soft_init_n || (|local_interrupt_lines) || busIntr;
  assign wbHit = wb_cyc_i && wb_stb_i && !ackReg_o;
  // a write lands on the edge at which the master sees ack high
  assign wbWr  = wb_cyc_i && wb_stb_i && wb_we_i && ackReg_o;

  // grant acknowledge cycle then fixed count to stop-grant
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackReg        <= AK_IDLE;
      ackCntReg     <= 5'h00;
      grantReadyReg <= 1'b0;
      grantAckCycle <= 1'b0;
    end else begin
      grantAckCycle <= 1'b0;
      grantReadyReg <= 1'b0;
      case (ackReg)
        AK_IDLE: begin
          if (stpc && !shutdownReg && !grantReadyReg &&
              (stateReg == ST_NORMAL || stateReg == ST_HALTED)) begin
            grantAckCycle <= 1'b1;
            ackReg        <= AK_WAIT;
          end
        end
        AK_WAIT: begin
          if (ackResponse) begin
            ackCntReg <= 5'h01;
            ackReg    <= AK_CNT;
          end
        end
        AK_CNT: begin
          if (ackCntReg == 5'(GRANT_DELAY)) begin
            grantReadyReg <= 1'b1;
            ackReg        <= AK_IDLE;
          end else begin
            ackCntReg <= ackCntReg + 5'h01;
          end
        end
        default: ackReg <= AK_IDLE;
      endcase
    end
  end

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_NORMAL: begin
        if (grantReadyReg) begin
          stateNext = ST_GRANT;
        end else if (haltExec) begin
          stateNext = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (grantReadyReg) begin
          stateNext = ST_GRANT;
        end else if (snoopSeen) begin
          stateNext = ST_SNOOP;
        end else if (wake) begin
          stateNext = ST_NORMAL;
        end
      end
      ST_GRANT: begin
        if (slp) begin
          stateNext = ST_SLEEP;
        end else if (snoopSeen) begin
          stateNext = ST_SNOOP;
        end else if (!stpc && bus_init_n) begin
          stateNext = (grantFromHaltReg && pend == 4'h0) ? ST_HALTED : ST_NORMAL;
        end
      end
      ST_SNOOP: begin
        if (snoopDone) begin
          stateNext = snoopRetReg;
        end
      end
      ST_SLEEP: begin
        if (!slp) begin
          stateNext = ST_GRANT;
        end
      end
      default: stateNext = ST_NORMAL;
    endcase
  end

  // processor reset forces normal outside stop-grant, and leaves sleep directly
  always_comb begin
    stateNew = stateNext;
    if (!proc_reset_n && stateReg != ST_GRANT) begin
      stateNew = ST_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stateReg    <= ST_NORMAL;
      snoopRetReg <= ST_NORMAL;
    end else begin
      stateReg <= stateNew;
      if (stateReg != ST_SNOOP && stateNew == ST_SNOOP) begin
        snoopRetReg <= stateReg;
      end
    end
  end

  // stop-grant exit returns to halted only when entered from it with nothing pending
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      grantFromHaltReg <= 1'b0;
    end else if (stateReg == ST_HALTED && stateNew == ST_GRANT) begin
      grantFromHaltReg <= 1'b1;
    end else if ((stateReg == ST_NORMAL && stateNew == ST_GRANT) || !proc_reset_n) begin
      grantFromHaltReg <= 1'b0;
    end
  end

  // wake events latched in stop-grant and snoop, one occurrence each, released in normal
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gEv
      lpt_event_latch uLatch (
        .clk     (clk),
        .rst_b   (rst_b),
        .setEv   (evIn[gi] && (stateReg == ST_GRANT || stateReg == ST_SNOOP)),
        .clrEv   (stateReg == ST_NORMAL),
        .pendReg (pend[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wakeService <= 4'h0;
      coreInit    <= 1'b0;
      lpState     <= ST_NORMAL;
    end else begin
      wakeService <= (stateReg == ST_NORMAL) ? pend : 4'h0;
      coreInit    <= !proc_reset_n;
      lpState     <= stateNew;
    end
  end

  // thermal throttle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      throttleReg <= 1'b0;
      hystReg     <= 32'h0000_0000;
    end else if (tempHigh && ctlReg.autoEn) begin
      throttleReg <= 1'b1;
      hystReg     <= HYST;
    end else if (hystReg != 32'h0000_0000) begin
      hystReg <= hystReg - 32'h0000_0001;
    end else begin
      throttleReg <= 1'b0;
    end
  end

  lpt_duty_mod #(
    .STEP_CY (STEP)
  ) uMod (
    .clk    (clk),
    .rst_b  (rst_b),
    .run    (throttleReg || ctlReg.demandEn),
    .duty   (throttleReg ? AUTO_DUTY : ctlReg.demandDuty),
    .gateOn (gateOn)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      coreClkEn         <= 1'b1;
      overtemp_active_n <= 1'b1;
    end else begin
      coreClkEn         <= gateOn && !shutdownReg && stateReg == ST_NORMAL;
      overtemp_active_n <= !(throttleReg || ctlReg.demandEn);
    end
  end

  // catastrophic shutdown survives proc_reset_n until cool
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shutdownReg        <= 1'b0;
      thermal_shutdown_n <= 1'b1;
    end else if (tempCatastrophic) begin
      shutdownReg        <= 1'b1;
      thermal_shutdown_n <= 1'b0;
    end else if (!proc_reset_n) begin
      shutdownReg        <= 1'b0;
      thermal_shutdown_n <= 1'b1;
    end
  end

  // wishbone slave, registered ack after one wait state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctlReg.autoEn     <= CTRL_RESET[CTRL_AUTO_BIT];
      ctlReg.demandEn   <= CTRL_RESET[CTRL_DEMAND_BIT];
      ctlReg.demandDuty <= CTRL_RESET[CTRL_DUTY_LSB +: 3];
    end else if (wbWr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      ctlReg.demandEn   <= wb_dat_i[CTRL_DEMAND_BIT];
      ctlReg.demandDuty <= wb_dat_i[CTRL_DUTY_LSB +: 3];
      ctlReg.autoEn     <= wb_dat_i[CTRL_AUTO_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackReg_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ackReg_o <= wbHit;
      wb_dat_o <= 32'h0000_0000;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL:   wb_dat_o <= {27'h0, ctlReg.demandEn, ctlReg.demandDuty, ctlReg.autoEn};
          ADDR_STATUS: wb_dat_o <= {24'h0, shutdownReg, throttleReg, 1'b0, stateReg};
          ADDR_PEND:   wb_dat_o <= {28'h0, pend};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ackReg_o;

  // checks
  sequence s_ackResp;
    ackReg == AK_WAIT && ackResponse;
  endsequence

  a_grant_delay_exact: assert property (@(posedge clk) disable iff (!rst_b)
    s_ackResp |-> ##21 grantReadyReg)
    else $error("stop-grant not reached 20 clocks after ack response");

  a_sleep_only_grant: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_SLEEP && $past(stateReg) != ST_SLEEP) |-> $past(stateReg) == ST_GRANT)
    else $error("sleep entered from a state other than stop-grant");

  a_snoop_return_path: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_SNOOP && snoopDone && proc_reset_n) |=> stateReg == $past(snoopRetReg))
    else $error("grant snoop did not return to origin");

  a_halt_wake_normal: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_HALTED && wake && !snoopSeen && !grantReadyReg) |=> stateReg == ST_NORMAL)
    else $error("halted state ignored wake event");

  a_overtemp_follows: assert property (@(posedge clk) disable iff (!rst_b)
    (throttleReg || ctlReg.demandEn) |=> !overtemp_active_n)
    else $error("over-temperature output not asserted while throttling");

  a_shutdown_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (shutdownReg && proc_reset_n) |=> !thermal_shutdown_n)
    else $error("shutdown output released without reset");

  a_reset_in_grant: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_GRANT && !proc_reset_n && stpc && !slp && !snoopSeen) |=> stateReg == ST_GRANT)
    else $error("reset left stop-grant while stop-clock held");

  a_hyst_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (throttleReg && hystReg != 32'h0000_0000) |=> throttleReg)
    else $error("throttle dropped before hysteresis expired");

  a_sleep_no_latch: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_SLEEP && pend == 4'h0) |=> pend == 4'h0)
    else $error("event latched during sleep");

  a_no_second_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (grantReadyReg || stateReg == ST_GRANT) |=> !grantAckCycle)
    else $error("acknowledge cycle repeated while entering stop-grant");

  a_grant_exit_halt: assert property (@(posedge clk) disable iff (!rst_b)
    (stateReg == ST_GRANT && !stpc && bus_init_n && !slp && !snoopSeen && proc_reset_n
      && grantFromHaltReg && pend == 4'h0) |=> stateReg == ST_HALTED)
    else $error("stop-clock withdrawal did not return to halted state");
endmodule
`default_nettype wire

// ===== lpt_chipset_model.sv
// chipset model: drives the stop-clock, sleep and reset sideband pins
// assumes: shares clk with the block; the bench sets the request levels
`default_nettype none
module lpt_chipset_model
  import lpt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bench requests
  input  wire logic       stopReq,
  input  wire logic       sleepReq,
  input  wire logic       resetReq,
  input  wire logic [2:0] ackDly,
  // block side
  input  wire logic       grantAckCycle,
  input  wire logic [4:0] lpState,
  output logic            stop_clock_request_n,
  output logic            sleep_request_n,
  output logic            proc_reset_n,
  output logic            ackResponse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sleepWasHigh;
  logic [3:0] ackCnt;
  wire  logic inGrant = (lpState == ST_GRANT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_clock_request_n <= 1'b1;
      sleep_request_n      <= 1'b1;
      proc_reset_n         <= 1'b1;
      sleepWasHigh         <= 1'b1;
    end else begin
      proc_reset_n <= !resetReq;
      sleepWasHigh <= sleep_request_n;
      if (resetReq && !sleep_request_n) begin
        sleep_request_n      <= 1'b1;
        stop_clock_request_n <= 1'b1;
      end else begin
        if (sleepReq && inGrant) sleep_request_n <= 1'b0;
        else if (!sleepReq) sleep_request_n <= 1'b1;
        if (stopReq) stop_clock_request_n <= 1'b0;
        else if (inGrant && sleep_request_n && sleepWasHigh) stop_clock_request_n <= 1'b1;
      end
    end
  end

  // bus response to the grant acknowledge cycle, prompt or slow
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackCnt      <= 4'h0;
      ackResponse <= 1'b0;
    end else begin
      ackResponse <= (ackCnt == 4'h1);
      if (grantAckCycle) ackCnt <= {1'b0, ackDly} + 4'h2;
      else if (ackCnt != 4'h0) ackCnt <= ackCnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== lpt_power_ctrl_test.sv
// self-checking bench for the low-power state and throttle block
// assumes: chipset model on the sideband pins, bench as wishbone master
`default_nettype none
module lpt_power_ctrl_test
  import lpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HYS = 16;
  localparam int STP = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  evt = 8'h00; // halt,busIntr,snoop,snoopDone,lint0,lint1,softInit,busInit
  logic        tempHigh = 1'b0;
  logic        tempCat = 1'b0;
  logic        stopReq = 1'b0;
  logic        sleepReq = 1'b0;
  logic        resetReq = 1'b0;
  logic [2:0]  ackDly = 3'h0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [3:0]  wbAdr = 4'h0;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] lfsr = 32'h34F48E50;
  logic [31:0] expQ[$];
  string       nameQ[$];
  int          errors = 0;
  int          total_checks = 0;
  int          n;
  wire logic        stopN, sleepN, procN, ackResp, grantAck, coreClkEn, coreInit;
  wire logic        ovtN, shutN, wbAck;
  wire logic [31:0] wbDatO;
  wire logic [4:0]  lpState;
  wire logic [3:0]  wakeService;

  always #4 clk = ~clk;

  lpt_power_ctrl #(.HYST(HYS), .STEP(STP)) DUT (
    .clk(clk), .rst_b(rst_b), .stop_clock_request_n(stopN), .sleep_request_n(sleepN),
    .bus_init_n(~evt[7]), .soft_init_n(~evt[6]), .proc_reset_n(procN),
    .local_interrupt_lines(evt[5:4]), .haltExec(evt[0]), .busIntr(evt[1]),
    .snoopSeen(evt[2]), .snoopDone(evt[3]), .ackResponse(ackResp), .busInitDone(1'b0),
    .tempHigh(tempHigh), .tempCatastrophic(tempCat), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .lpState(lpState), .grantAckCycle(grantAck), .coreClkEn(coreClkEn),
    .coreInit(coreInit), .wakeService(wakeService), .overtemp_active_n(ovtN),
    .thermal_shutdown_n(shutN));

  lpt_chipset_model CHIP (
    .clk(clk), .rst_b(rst_b), .stopReq(stopReq), .sleepReq(sleepReq), .resetReq(resetReq),
    .ackDly(ackDly), .grantAckCycle(grantAck), .lpState(lpState),
    .stop_clock_request_n(stopN), .sleep_request_n(sleepN), .proc_reset_n(procN),
    .ackResponse(ackResp));

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic pulse(input int b);
    @(posedge clk) evt[b] <= 1'b1;
    @(posedge clk) evt[b] <= 1'b0;
  endtask

  // one classic cycle; on a read d is the expected data
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input string w);
    int k;
    k = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    if (!we) begin
      expQ.push_back(d);
      nameQ.push_back(w);
    end
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (k >= 20) check("wb ack", 32'h0, 32'h1);
  endtask

  task automatic waitSt(input logic [4:0] e);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (lpState !== e && n < 300);
  endtask

  task automatic st(input logic [4:0] e);
    @(posedge clk);
    #1;
    check("state", 32'(lpState), 32'(e));
  endtask

  task automatic duty(input int exp);
    int c;
    c = 0;
    tick(40);
    repeat (32) begin
      @(posedge clk);
      #1;
      if (coreClkEn === 1'b1) c++;
    end
    check("on cycles", c, exp);
    check("overtemp", 32'(ovtN), 32'h0);
  endtask

  task automatic toGrant;
    @(posedge clk);
    ackDly  <= lfsr[2:0];
    stopReq <= 1'b1;
    lfsr = lfsrNext(lfsr);
    waitSt(ST_GRANT);
  endtask

  // read results are compared as the acks come back
  always @(posedge clk)
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
      check(nameQ.pop_front(), wbDatO, expQ.pop_front());

  initial begin
    tick(20000);
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    tick(5);
    rst_b <= 1'b1;
    wb(1'b0, ADDR_CTRL, CTRL_RESET, "ctrl reset");
    wb(1'b1, 4'hC, 32'h0000_001E, "");
    wb(1'b0, 4'hC, 32'h0, "unmapped");
    wb(1'b0, ADDR_CTRL, CTRL_RESET, "ctrl kept");
    for (int i = 0; i < 5; i++) begin
      pulse(0);
      st(ST_HALTED);
      pulse(i == 0 ? 1 : i + 3);
      waitSt(ST_NORMAL);
      check("wake", n, 1);
    end
    $display("test halt done");
    pulse(0);
    toGrant();
    stopReq <= 1'b0;
    waitSt(ST_HALTED);
    check("back to halted", n < 300, 1);
    pulse(3);
    $display("test stop in halt done");
    @(posedge clk) stopReq <= 1'b1;
    n = 0;
    while (grantAck !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("grant cycle", n < 50, 1);
    while (ackResp !== 1'b1) @(posedge clk);
    waitSt(ST_GRANT);
    check("grant delay", n >= 20 && n <= 22, 1);
    pulse(2);
    st(ST_SNOOP);
    pulse(3);
    st(ST_GRANT);
    pulse(7);
    tick(3);
    st(ST_GRANT);
    pulse(4);
    pulse(6);
    pulse(6);
    stopReq <= 1'b0;
    waitSt(ST_NORMAL);
    tick(1);
    #1;
    check("wake latched", 32'(wakeService), 32'hD);
    $display("test stop grant done");
    toGrant();
    @(posedge clk) resetReq <= 1'b1;
    @(posedge clk) resetReq <= 1'b0;
    st(ST_GRANT);
    check("init", 32'(coreInit), 32'h1);
    stopReq <= 1'b0;
    waitSt(ST_NORMAL);
    check("reset exit", n < 300, 1);
    toGrant();
    sleepReq <= 1'b1;
    waitSt(ST_SLEEP);
    check("sleep", n < 300, 1);
    @(posedge clk) sleepReq <= 1'b0;
    stopReq <= 1'b0;
    waitSt(ST_GRANT);
    check("wake to grant", n < 300, 1);
    waitSt(ST_NORMAL);
    toGrant();
    sleepReq <= 1'b1;
    waitSt(ST_SLEEP);
    @(posedge clk) resetReq <= 1'b1;
    stopReq  <= 1'b0;
    sleepReq <= 1'b0;
    @(posedge clk) resetReq <= 1'b0;
    tick(2);
    st(ST_NORMAL);
    $display("test sleep done");
    for (int d = 0; d < 8; d++) begin
      wb(1'b1, ADDR_CTRL, 32'h10 | (d << 1), "");
      duty((d + 1) * STP);
    end
    tempHigh <= 1'b1;
    wb(1'b1, ADDR_CTRL, 32'h11, "");
    duty((AUTO_DUTY + 1) * STP);
    wb(1'b1, ADDR_CTRL, 32'h01, "");
    duty((AUTO_DUTY + 1) * STP);
    @(posedge clk) tempHigh <= 1'b0;
    tick(HYS - 2);
    check("hold", 32'(ovtN), 32'h0);
    tick(HYS + 80);
    check("released", 32'(ovtN), 32'h1);
    $display("test throttle done");
    @(posedge clk) tempCat <= 1'b1;
    tick(3);
    check("trip", 32'(shutN), 32'h0);
    @(posedge clk) tempCat <= 1'b0;
    tick(3);
    check("trip held", 32'(shutN), 32'h0);
    @(posedge clk) rst_b <= 1'b0;
    tick(5);
    rst_b <= 1'b1;
    tick(2);
    check("trip cleared", 32'(shutN), 32'h1);
    wb(1'b0, ADDR_CTRL, CTRL_RESET, "ctrl after reset");
    $display("test shutdown done");
    tick(3);
    report_and_stop();
  end
endmodule
`default_nettype wire
